// ===== src/wdru_top.sv
// watchdog and system reset control unit
// How it works
// - reset loads program counter from top vector, high byte first
// - stack pointer forced to its fixed start value during reset
// - interrupt mask bit set during reset, blocking maskable interrupts
// - reset disables peripherals; pins become unpulled high-z inputs
// - sources: power-on, low voltage, watchdog, opcode, debug, pin, clock
// - each source except debug force sets its own cause flag
// - reset puts clock generator in self-clocked mode, bus at half rate
// - reset pin driven low 34 bus cycles, then released to pull-up
// - pin sampled 38 cycles after release; low marks pin as cause
// - watchdog resets system if counter reaches overflow before service
// - watchdog enable set after every reset; clearing it disables it
// - any write to cause address clears counter, status unchanged
// - clock select picks bus or slow source; timeout select short/long
// - kilohertz source: 32 counts or 256 counts
// - bus source: 2^13 or 2^18 cycles; default bus with long timeout
// - option registers take only the first write after reset
// - first write to either option register clears the counter
// - counter holds while in background debug mode
// - bus source: counter freezes in stop and resumes from held value
// - slow source: counter cleared on stop entry, counts from zero after
`timescale 1ns/1ps
`include "wdru_defines.svh"

module wdru_top
  import wdru_pkg::*;
#(
  parameter int BUS_SHORT_CYC = `WDRU_BUS_SHORT_CYC,
  parameter int BUS_LONG_CYC  = `WDRU_BUS_LONG_CYC,
  parameter int KHZ_SHORT_CNT = `WDRU_KHZ_SHORT_CNT,
  parameter int KHZ_LONG_CNT  = `WDRU_KHZ_LONG_CNT
) (
  input  wire logic           clk_i,            // bus clock
  input  wire logic           sys_rst_i,        // power-on reset, sync high
  input  wire wdru_src_t      src_i,            // reset requests
  input  wire logic           reset_pin_in_i,   // reset pin level
  input  wire logic           khz_tick_i,       // one pulse per ~1 ms
  input  wire logic           bdm_active_i,     // background debug mode
  input  wire logic           stop_mode_i,      // stop mode
  input  wire logic [7:0]     addr_i,           // register address
  input  wire logic [7:0]     wdata_i,          // write data
  input  wire logic           wr_i,             // write strobe
  input  wire logic           rd_i,             // read strobe
  output logic      [7:0]     rdata_o,          // read data, next cycle
  output logic                reset_pin_o,      // reset pin drive level
  output logic                reset_pin_oe_o,   // reset pin drive enable
  output logic                sys_reset_o,      // internal system reset
  output wdru_cpu_init_t      cpu_init_o,       // processor start state
  output logic                periph_disable_o, // peripherals held off
  output logic                io_default_o,     // pins to unpulled inputs
  output logic                clkgen_self_o,    // clock gen self-clocked
  output logic                bus_half_rate_o   // bus at half gen rate
);

  // one bit spare so that a limit of exactly 2^18 still fits
  localparam int CW = 19;
  localparam int PW = 6;

  wdru_state_t    state_r;
  logic [PW-1:0]  seq_cnt_r;
  logic [7:0]     cause_r;
  logic           wd_enable_r;
  logic           wd_tsel_r;
  logic           wd_clksel_r;
  logic           lock1_r;
  logic           lock2_r;
  logic [CW-1:0]  wd_cnt_r;
  logic           stop_d_r;

  logic           in_reset;
  logic           pin_low_run;
  logic           any_src;
  logic           wd_timeout;
  logic           wd_tick;
  logic           wd_clear;
  logic           stop_entry;
  logic [CW-1:0]  wd_limit;
  logic [7:0]     src_bits;
  logic           wr_cause;
  logic           wr_opt1;
  logic           wr_opt2;
  logic           drive_last;
  logic           sample_now;
  logic           leave_reset;

  assign in_reset    = (state_r != WDRU_RUN);
  assign pin_low_run = !reset_pin_in_i && (state_r == WDRU_RUN);
  assign wr_cause    = wr_i && (addr_i == `WDRU_ADDR_CAUSE);
  assign wr_opt1     = wr_i && (addr_i == `WDRU_ADDR_OPT_ONCE);
  assign wr_opt2     = wr_i && (addr_i == `WDRU_ADDR_OPT_SECOND);
  assign stop_entry  = stop_mode_i && !stop_d_r;

  // end points of the drive and wait phases
  assign drive_last  = (state_r == WDRU_DRIVE) &&
                       (seq_cnt_r == PW'(`WDRU_PIN_DRIVE_CYC - 1));
  assign sample_now  = (state_r == WDRU_WAIT) &&
                       (seq_cnt_r == PW'(`WDRU_PIN_SAMPLE_CYC - 1));
  // reset ends when the pin reads high at the sample, or later in hold
  assign leave_reset = reset_pin_in_i &&
                       ((sample_now && !any_src) || (state_r == WDRU_HOLD));

  // cause bits from this cycle's requests; debug force has no flag
  always_comb begin
    src_bits = 8'h00;
    src_bits[`WDRU_CAUSE_POR]     = src_i.por;
    src_bits[`WDRU_CAUSE_LVD]     = src_i.low_voltage_detect;
    src_bits[`WDRU_CAUSE_ILLOP]   = src_i.illop;
    src_bits[`WDRU_CAUSE_CLKLOSS] = src_i.clk_loss;
    src_bits[`WDRU_CAUSE_WDOG]    = wd_timeout;
  end

  assign any_src = src_i.por || src_i.low_voltage_detect || src_i.illop ||
                   src_i.bdm_force || src_i.clk_loss ||
                   wd_timeout || pin_low_run;

  // overflow count from the two select bits
  always_comb begin
    if (wd_clksel_r) begin
      wd_limit = wd_tsel_r ? CW'(BUS_LONG_CYC) : CW'(BUS_SHORT_CYC);
    end else begin
      wd_limit = wd_tsel_r ? CW'(KHZ_LONG_CNT) : CW'(KHZ_SHORT_CNT);
    end
  end

  // bus source counts every cycle, the slow source on its tick only
  always_comb begin
    if (!wd_enable_r || in_reset || bdm_active_i || stop_mode_i) begin
      wd_tick = 1'b0;
    end else if (wd_clksel_r) begin
      wd_tick = 1'b1;
    end else begin
      wd_tick = khz_tick_i;
    end
  end

  assign wd_timeout = wd_tick && (wd_cnt_r == wd_limit - CW'(1));

  // servicing via the cause address, or the first option writes
  assign wd_clear = wr_cause ||
                    (wr_opt1 && !lock1_r) ||
                    (wr_opt2 && !lock2_r);

  // reset pin sequence
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_r   <= WDRU_DRIVE;
      seq_cnt_r <= '0;
    end else begin
      case (state_r)
        WDRU_RUN: begin
          if (any_src) begin
            state_r   <= WDRU_DRIVE;
            seq_cnt_r <= '0;
          end
        end
        WDRU_DRIVE: begin
          if (any_src && !pin_low_run) begin
            seq_cnt_r <= '0;
          end else if (seq_cnt_r == PW'(`WDRU_PIN_DRIVE_CYC - 1)) begin
            state_r   <= WDRU_WAIT;
            seq_cnt_r <= '0;
          end else begin
            seq_cnt_r <= seq_cnt_r + PW'(1);
          end
        end
        WDRU_WAIT: begin
          if (any_src) begin
            state_r   <= WDRU_DRIVE;
            seq_cnt_r <= '0;
          end else if (seq_cnt_r == PW'(`WDRU_PIN_SAMPLE_CYC - 1)) begin
            state_r   <= reset_pin_in_i ? WDRU_RUN : WDRU_HOLD;
            seq_cnt_r <= '0;
          end else begin
            seq_cnt_r <= seq_cnt_r + PW'(1);
          end
        end
        WDRU_HOLD: begin
          // stay in reset while someone outside keeps the pin low
          if (reset_pin_in_i) begin
            state_r <= WDRU_RUN;
          end
        end
        default: begin
          state_r   <= WDRU_DRIVE;
          seq_cnt_r <= '0;
        end
      endcase
    end
  end

  // cause register: cleared on a fresh reset, sources accumulate inside one
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cause_r <= 8'h00;
      cause_r[`WDRU_CAUSE_POR] <= 1'b1;
    end else if (state_r == WDRU_RUN && any_src) begin
      cause_r <= src_bits;
    end else if (in_reset) begin
      cause_r <= cause_r | src_bits;
      if (state_r == WDRU_WAIT && !reset_pin_in_i &&
          seq_cnt_r == PW'(`WDRU_PIN_SAMPLE_CYC - 1)) begin
        cause_r[`WDRU_CAUSE_PIN] <= 1'b1;
      end
    end
  end

  // write-once options; any reset restores defaults and reopens them
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || in_reset) begin
      wd_enable_r <= `WDRU_ENABLE_RST;
      wd_tsel_r   <= `WDRU_TSEL_RST;
      wd_clksel_r <= `WDRU_CLKSEL_RST;
      lock1_r     <= 1'b0;
      lock2_r     <= 1'b0;
    end else begin
      if (wr_opt1 && !lock1_r) begin
        wd_enable_r <= wdata_i[`WDRU_OPT_ENABLE_BIT];
        wd_tsel_r   <= wdata_i[`WDRU_OPT_TSEL_BIT];
        lock1_r     <= 1'b1;
      end
      if (wr_opt2 && !lock2_r) begin
        wd_clksel_r <= wdata_i[`WDRU_OPT2_CLKSEL_BIT];
        lock2_r     <= 1'b1;
      end
    end
  end

  // watchdog counter
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || in_reset) begin
      wd_cnt_r <= '0;
    end else if (wd_clear || wd_timeout) begin
      wd_cnt_r <= '0;
    end else if (!wd_clksel_r && stop_entry) begin
      wd_cnt_r <= '0;
    end else if (wd_tick) begin
      wd_cnt_r <= wd_cnt_r + CW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      stop_d_r <= 1'b0;
    end else begin
      stop_d_r <= stop_mode_i;
    end
  end

  // register reads; unmapped addresses return zero
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `WDRU_ADDR_CAUSE: begin
          rdata_o <= cause_r;
        end
        `WDRU_ADDR_OPT_ONCE: begin
          rdata_o <= 8'h00;
          rdata_o[`WDRU_OPT_ENABLE_BIT] <= wd_enable_r;
          rdata_o[`WDRU_OPT_TSEL_BIT]   <= wd_tsel_r;
        end
        `WDRU_ADDR_OPT_SECOND: begin
          rdata_o <= 8'h00;
          rdata_o[`WDRU_OPT2_CLKSEL_BIT] <= wd_clksel_r;
        end
        `WDRU_ADDR_STATUS: begin
          rdata_o <= 8'h00;
          rdata_o[`WDRU_STAT_COUNTING] <= wd_tick;
          rdata_o[`WDRU_STAT_LOCK1]    <= lock1_r;
          rdata_o[`WDRU_STAT_LOCK2]    <= lock2_r;
        end
        default: begin
          rdata_o <= 8'h00;
        end
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // reset pin: open drain, only ever pulled low; the pull-up restores it
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      reset_pin_o    <= 1'b0;
      reset_pin_oe_o <= 1'b1;
    end else begin
      reset_pin_o    <= 1'b0;
      // a source in drive or wait restarts the full drive without a gap
      reset_pin_oe_o <= (any_src && state_r != WDRU_HOLD) ||
                        ((state_r == WDRU_DRIVE) && !drive_last);
    end
  end

  // system reset stands from the first source until the exit cycle
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sys_reset_o <= 1'b1;
    end else if (in_reset) begin
      sys_reset_o <= !leave_reset;
    end else begin
      sys_reset_o <= any_src;
    end
  end

  // quiet chip state follows the reset window, one cycle late at exit
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      periph_disable_o <= 1'b1;
      io_default_o     <= 1'b1;
    end else begin
      periph_disable_o <= in_reset || any_src;
      io_default_o     <= in_reset || any_src;
    end
  end

  // clock setup; half rate is set by reset and held, nothing in this unit clears it
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      clkgen_self_o   <= 1'b1;
      bus_half_rate_o <= 1'b1;
    end else begin
      clkgen_self_o <= in_reset || any_src;
      if (in_reset || any_src) begin
        bus_half_rate_o <= 1'b1;
      end
    end
  end

  // processor start state, load pulses in the cycle reset ends
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cpu_init_o.vector_addr <= `WDRU_RESET_VECTOR;
      cpu_init_o.sp_init     <= `WDRU_SP_INIT;
      cpu_init_o.imask_set   <= 1'b1;
      cpu_init_o.load        <= 1'b0;
    end else begin
      cpu_init_o.vector_addr <= `WDRU_RESET_VECTOR;
      cpu_init_o.sp_init     <= `WDRU_SP_INIT;
      cpu_init_o.imask_set   <= in_reset || any_src;
      cpu_init_o.load        <= leave_reset;
    end
  end

endmodule

// ===== src/wdru_defines.svh
// constants of the watchdog and reset unit
`ifndef WDRU_DEFINES_SVH
`define WDRU_DEFINES_SVH

// register offsets
`define WDRU_ADDR_CAUSE        8'h00
`define WDRU_ADDR_OPT_ONCE     8'h01
`define WDRU_ADDR_OPT_SECOND   8'h02
`define WDRU_ADDR_STATUS       8'h03

// reset cause register bit positions
`define WDRU_CAUSE_POR         7
`define WDRU_CAUSE_PIN         6
`define WDRU_CAUSE_WDOG        5
`define WDRU_CAUSE_ILLOP       4
`define WDRU_CAUSE_CLKLOSS     3
`define WDRU_CAUSE_LVD         1

// option register bit positions and reset values
`define WDRU_OPT_ENABLE_BIT    7
`define WDRU_OPT_TSEL_BIT      6
`define WDRU_OPT2_CLKSEL_BIT   7
`define WDRU_ENABLE_RST        1'b1
`define WDRU_TSEL_RST          1'b1
`define WDRU_CLKSEL_RST        1'b1

// status register bit positions
`define WDRU_STAT_COUNTING     0
`define WDRU_STAT_LOCK1        1
`define WDRU_STAT_LOCK2        2

// cpu start state
`define WDRU_RESET_VECTOR      16'hfffe
`define WDRU_SP_INIT           16'h00ff

// reset pin sequence, in bus cycles
`define WDRU_PIN_DRIVE_CYC     34
`define WDRU_PIN_SAMPLE_CYC    38

// watchdog overflow counts
`define WDRU_BUS_SHORT_CYC     8192
`define WDRU_BUS_LONG_CYC      262144
`define WDRU_KHZ_RATE_PER_MS   1
`define WDRU_KHZ_SHORT_MS      32
`define WDRU_KHZ_LONG_MS       256
`define WDRU_KHZ_SHORT_CNT     (`WDRU_KHZ_SHORT_MS * `WDRU_KHZ_RATE_PER_MS)
`define WDRU_KHZ_LONG_CNT      (`WDRU_KHZ_LONG_MS * `WDRU_KHZ_RATE_PER_MS)

`endif

// ===== src/wdru_pkg.sv
// types of the watchdog and reset unit
package wdru_pkg;

  typedef enum logic [1:0] {
    WDRU_RUN,
    WDRU_DRIVE,
    WDRU_WAIT,
    WDRU_HOLD
  } wdru_state_t;

  // start state handed to the processor core
  typedef struct packed {
    logic [15:0] vector_addr;
    logic [15:0] sp_init;
    logic        imask_set;
    logic        load;
  } wdru_cpu_init_t;

  // reset requests from the rest of the chip
  typedef struct packed {
    logic por;
    logic low_voltage_detect;
    logic illop;
    logic bdm_force;
    logic clk_loss;
  } wdru_src_t;

endpackage

// ===== verif/wdru_props.sv
// assertion checker of the watchdog and reset unit
`timescale 1ns/1ps

module wdru_props
  import wdru_pkg::*;
#(
  parameter int BUS_SHORT_CYC = 64,
  parameter int BUS_LONG_CYC  = 128,
  parameter int KHZ_SHORT_CNT = 32,
  parameter int KHZ_LONG_CNT  = 256
) (
  input wire logic           clk_i,            // clock
  input wire logic           sys_rst_i,        // reset
  input wire wdru_src_t      src_i,            // sources
  input wire logic           reset_pin_in_i,   // pin level
  input wire logic           khz_tick_i,       // slow tick
  input wire logic           bdm_active_i,     // debug
  input wire logic           stop_mode_i,      // stop
  input wire logic [7:0]     addr_i,           // address
  input wire logic [7:0]     wdata_i,          // write data
  input wire logic           wr_i,             // write
  input wire logic           rd_i,             // read
  input wire logic [7:0]     rdata_o,          // read data
  input wire logic           reset_pin_o,      // pin level out
  input wire logic           reset_pin_oe_o,   // pin enable
  input wire logic           sys_reset_o,      // system reset
  input wire wdru_cpu_init_t cpu_init_o,       // start state
  input wire logic           periph_disable_o, // peripherals off
  input wire logic           io_default_o,     // pins default
  input wire logic           clkgen_self_o,    // self clocked
  input wire logic           bus_half_rate_o   // half rate
);
  logic [7:0] oe_len_r;  // cycles the pin has been driven
  logic [7:0] rel_len_r; // cycles in reset since the pin was let go

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !reset_pin_oe_o) oe_len_r <= 8'h00;
    else oe_len_r <= oe_len_r + 8'h01;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !sys_reset_o || reset_pin_oe_o) rel_len_r <= 8'h00;
    else rel_len_r <= rel_len_r + 8'h01;
  end

  pin_drive_a: assert property (
    $fell(reset_pin_oe_o) |-> oe_len_r >= 8'h22)
    else $error("pin released early");
  pin_low_a: assert property (reset_pin_oe_o |-> !reset_pin_o)
    else $error("pin driven high");
  pin_wait_a: assert property (
    $fell(sys_reset_o) |-> rel_len_r >= 8'h26)
    else $error("reset left before pin sample");
  load_exit_a: assert property (cpu_init_o.load |->
    $fell(sys_reset_o) ##1 !cpu_init_o.load) else $error("load pulse wrong");
  start_state_a: assert property (cpu_init_o.load |->
    cpu_init_o.vector_addr == 16'hfffe && cpu_init_o.sp_init == 16'h00ff)
    else $error("start state wrong");
  imask_held_a: assert property (
    sys_reset_o |-> cpu_init_o.imask_set) else $error("mask clear in reset");
  quiet_io_a: assert property (
    sys_reset_o && $past(sys_reset_o) |->
    periph_disable_o && io_default_o && clkgen_self_o)
    else $error("io not quiet in reset");
  half_rate_a: assert property (
    $past(sys_reset_o) |-> bus_half_rate_o) else $error("bus not half rate");
  src_entry_a: assert property (!sys_reset_o && (|src_i) |=>
    sys_reset_o && reset_pin_oe_o) else $error("source ignored");

  cover property ($fell(sys_reset_o));
  cover property (!sys_reset_o && (|src_i));
  cover property ($fell(reset_pin_oe_o));
  cover property (sys_reset_o && !reset_pin_oe_o && !reset_pin_in_i);
endmodule

// ===== verif/tb_top.sv
// self-checking bench of the watchdog and reset unit
`timescale 1ns/1ps

module tb_top
  import wdru_pkg::*;
;
  localparam int BS = 64;
  localparam int BL = 128;
  localparam int KS = 32;
  localparam int KL = 256;
  localparam int TP = 4; // bus cycles per slow tick, shortened for run time
  localparam logic [7:0] CAUSE_TBL [5] = '{8'h08, 8'h00, 8'h10, 8'h02, 8'h80};

  logic           clk_i = 1'b0;
  logic           sys_rst_i = 1'b1;
  wdru_src_t      src_i = 5'h00;
  logic           ext_hold = 1'b0;
  logic           khz_tick_i = 1'b0;
  logic           bdm_active_i = 1'b0;
  logic           stop_mode_i = 1'b0;
  logic [7:0]     addr_i = 8'h00;
  logic [7:0]     wdata_i = 8'h00;
  logic           wr_i = 1'b0;
  logic           rd_i = 1'b0;
  logic [7:0]     rdata_o;
  logic           reset_pin_o;
  logic           reset_pin_oe_o;
  logic           sys_reset_o;
  wdru_cpu_init_t cpu_init_o;
  logic           periph_disable_o;
  logic           io_default_o;
  logic           clkgen_self_o;
  logic           bus_half_rate_o;
  wire            reset_pin_in_i;
  logic [1:0]     tick_cnt = 2'h0;
  logic [31:0]    lfsr_r = 32'h21cf1086;
  int             error_cnt = 0;
  int             checks_done = 0;

  // open drain with pull-up: low if the unit or the outside holds it
  assign reset_pin_in_i = !(reset_pin_oe_o && !reset_pin_o) && !ext_hold;

  initial forever #5 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    tick_cnt <= tick_cnt + 2'h1;
    khz_tick_i <= (tick_cnt == 2'h3);
  end

  wdru_top #(.BUS_SHORT_CYC(BS), .BUS_LONG_CYC(BL), .KHZ_SHORT_CNT(KS),
    .KHZ_LONG_CNT(KL)) dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .src_i(src_i),
    .reset_pin_in_i(reset_pin_in_i), .khz_tick_i(khz_tick_i),
    .bdm_active_i(bdm_active_i), .stop_mode_i(stop_mode_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .reset_pin_o(reset_pin_o),
    .reset_pin_oe_o(reset_pin_oe_o), .sys_reset_o(sys_reset_o),
    .cpu_init_o(cpu_init_o), .periph_disable_o(periph_disable_o),
    .io_default_o(io_default_o), .clkgen_self_o(clkgen_self_o),
    .bus_half_rate_o(bus_half_rate_o));

  function automatic logic [31:0] next_rnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // overflow in bus cycles for clock select and timeout select
  function automatic int wd_limit(input logic [1:0] md);
    return md[1] ? (md[0] ? BL : BS) : (md[0] ? KL : KS) * TP;
  endfunction

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m,
                        input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 check(rdata_o & m, e);
  endtask

  task automatic to_reset(input int lim, output int n);
    n = 0;
    while (!sys_reset_o && n < lim) begin
      @(posedge clk_i);
      #1 n++;
    end
  endtask

  // entered just after an edge while in reset; leaves at the exit cycle
  task automatic ride(input bit exact);
    int oe_n;
    int wt_n;
    oe_n = 0;
    wt_n = 0;
    while (sys_reset_o && wt_n < 1000) begin
      if (reset_pin_oe_o) oe_n++;
      else wt_n++;
      @(posedge clk_i);
      #1;
    end
    check(sys_reset_o, 1'b0);
    if (sys_reset_o) begin
      give_verdict();
    end else begin
      if (exact) check(oe_n, 34);
      if (exact) check(wt_n, 38);
      check({cpu_init_o.load, cpu_init_o.vector_addr, cpu_init_o.sp_init},
            {1'b1, 16'hfffe, 16'h00ff});
    end
  endtask

  initial begin
    int n;
    int lim;
    int expv;
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    #1 ride(1'b0);
    rd_chk(8'h00, 8'hff, 8'h80);
    rd_chk(8'h01, 8'hc0, 8'hc0);
    rd_chk(8'h02, 8'h80, 8'h80);
    rd_chk(8'h03, 8'h06, 8'h00);
    rd_chk(8'h7f, 8'hff, 8'h00);
    repeat (8) begin
      lfsr_r = next_rnd(lfsr_r);
      wr(8'h00, lfsr_r[7:0]);
      to_reset(BL / 2, n);
    end
    check(sys_reset_o, 1'b0);
    rd_chk(8'h00, 8'hff, 8'h80);
    // last service right before the timed wait, so it starts from zero
    wr(8'h00, lfsr_r[15:8]);
    to_reset(4 * BL, n);
    check(n + 8 >= BL && n <= BL + 2, 1'b1);
    ride(1'b1);
    rd_chk(8'h00, 8'hff, 8'h20);
    // stop then debug, both with the bus clock source
    for (int k = 0; k < 2; k++) begin
      wr(8'h00, 8'h00);
      repeat (BL / 2) @(posedge clk_i);
      stop_mode_i <= (k == 0);
      bdm_active_i <= (k == 1);
      repeat (2 * BL) @(posedge clk_i);
      check(sys_reset_o, 1'b0);
      stop_mode_i <= 1'b0;
      bdm_active_i <= 1'b0;
      #1 to_reset(BL, n);
      check(n + 8 >= BL / 2 && n <= BL / 2 + 4, 1'b1);
      ride(1'b1);
    end
    // every source once, every clock and timeout choice
    for (int m = 0; m < 5; m++) begin
      @(posedge clk_i);
      src_i <= 5'h01 << m;
      @(posedge clk_i);
      src_i <= 5'h00;
      #1 ride(1'b1);
      rd_chk(8'h00, 8'hff, CAUSE_TBL[m]);
      repeat (40) @(posedge clk_i);
      lim = wd_limit(m[1:0]);
      wr(8'h01, {1'b1, m[0], 6'h00});
      wr(8'h02, {m[1], 7'h00});
      wr(8'h01, 8'h00);
      rd_chk(8'h01, 8'hc0, {1'b1, m[0], 6'h00});
      rd_chk(8'h03, 8'h06, 8'h06);
      repeat (lim / 2 - 8) @(posedge clk_i);
      stop_mode_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      stop_mode_i <= 1'b0;
      #1 to_reset(2 * lim, n);
      expv = m[1] ? lim - lim / 2 : lim;
      check(n + 8 >= expv && n <= expv + 8, 1'b1);
      ride(1'b1);
    end
    wr(8'h01, 8'h00);
    to_reset(4 * BL, n);
    check(n, 4 * BL);
    @(posedge clk_i);
    ext_hold <= 1'b1;
    src_i <= 5'h08;
    @(posedge clk_i);
    src_i <= 5'h00;
    repeat (120) @(posedge clk_i);
    ext_hold <= 1'b0;
    #1 ride(1'b0);
    rd_chk(8'h00, 8'hff, 8'h42);
    give_verdict();
  end
endmodule

bind wdru_top wdru_props #(.BUS_SHORT_CYC(BUS_SHORT_CYC),
  .BUS_LONG_CYC(BUS_LONG_CYC), .KHZ_SHORT_CNT(KHZ_SHORT_CNT),
  .KHZ_LONG_CNT(KHZ_LONG_CNT)) u_props (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .src_i(src_i),
  .reset_pin_in_i(reset_pin_in_i), .khz_tick_i(khz_tick_i),
  .bdm_active_i(bdm_active_i), .stop_mode_i(stop_mode_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .reset_pin_o(reset_pin_o),
  .reset_pin_oe_o(reset_pin_oe_o), .sys_reset_o(sys_reset_o),
  .cpu_init_o(cpu_init_o), .periph_disable_o(periph_disable_o),
  .io_default_o(io_default_o), .clkgen_self_o(clkgen_self_o),
  .bus_half_rate_o(bus_half_rate_o));
